/* focp_port.sv */
/*
 Serial configuration port and output control of an eight-output fanout
 buffer: shift register, latch on load strobe, enable gating and type
 selection, serial read-back.
 Assumes the serial clock, data, strobe and gate pins are asynchronous to
 i_clk and slow enough (serial clock period well above six i_clk periods).
*/
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Gate low forces every output static
// - Gate and strobe high after a load: follow each enable bit
// - Before first load: static, LVDS type
// - Disabled outputs held static, not toggling
// - D2 types banks BCD, D1 bank A
// - D10..D3 enable individual outputs
// - Outputs toggle only while strobe high
// - Strobe rising high loads active word
// - Strobe low keeps previous configuration
// - Serial read-back output provided
module focp_port
    import focp_pkg::*;
(
    input wire logic i_clk, // System clock, 125 MHz
    input wire logic i_rstn, // Synchronous reset, active low
    input wire logic i_serial_clk, // Serial port clock pin
    input wire logic i_serial_config_in, // Serial data pin
    input wire logic i_load_strobe, // Load strobe pin
    input wire logic i_output_gate, // Global output enable pin
    output logic [7:0] o_out_run, // Per output: toggling allowed
    output logic o_a_bank_type_bit, // Bank A type, 1 = LVPECL
    output logic o_bcd_bank_type_bit, // Banks B/C/D type, 1 = LVPECL
    output logic o_readback, // Serial data output
    output logic o_configured // A word has been loaded
);
    import focp_pkg::*;
    ////////////////////////////////////////////////////////////////////
    logic sclk_s, sdat_s, le_s, gate_s;
    logic sclk_d_ff;
    logic [9:0] shift_ff;
    logic [9:0] word_ff;
    logic le_d_ff;
    logic configured_ff;
    logic sclk_rise, sclk_fall, le_rise;

    // Enable field of a word, one bit per output, D10 at the top
    function automatic logic [N_OUT-1:0] focp_run_bits(input logic [WORD_W-1:0] word);
        return word[WORD_W-1:POS_EN_LO];
    endfunction : focp_run_bits

    // Clock and data share one synchroniser depth, so their relative
    // timing at the pins is kept inside
    focp_sync u_sync_sclk (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_async(i_serial_clk),
        .o_level(sclk_s)
    );
    focp_sync u_sync_sdat (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_async(i_serial_config_in),
        .o_level(sdat_s)
    );
    focp_sync u_sync_le (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_async(i_load_strobe),
        .o_level(le_s)
    );
    focp_sync u_sync_gate (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_async(i_output_gate),
        .o_level(gate_s)
    );

    assign sclk_rise = sclk_s && !sclk_d_ff;
    assign sclk_fall = !sclk_s && sclk_d_ff;
    assign le_rise = le_s && !le_d_ff;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            sclk_d_ff <= 1'b0;
            le_d_ff <= 1'b0;
        end else begin
            sclk_d_ff <= sclk_s;
            le_d_ff <= le_s;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Shift in, first bit ends at the top (D10)
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            shift_ff <= WORD_RESET;
        end else if (sclk_rise) begin
            shift_ff <= {shift_ff[8:0], sdat_s};
        end
    end

    // Read-back shows the oldest bit, updated on the falling edge so the
    // host samples a settled level on its next rising edge
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_readback <= 1'b0;
        end else if (sclk_fall || le_rise) begin
            o_readback <= shift_ff[WORD_W-1];
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Active word only moves on the strobe's rising edge
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            word_ff <= WORD_RESET;
            configured_ff <= 1'b0;
        end else if (le_rise) begin
            word_ff <= shift_ff;
            configured_ff <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Outputs run only if gated on, enabled, configured and strobe high
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_out_run <= EN_RESET;
            o_a_bank_type_bit <= TYPE_LVDS;
            o_bcd_bank_type_bit <= TYPE_LVDS;
            o_configured <= 1'b0;
        end else begin
            o_configured <= configured_ff;
            if (!configured_ff) begin
                o_out_run <= EN_RESET;
                o_a_bank_type_bit <= TYPE_LVDS;
                o_bcd_bank_type_bit <= TYPE_LVDS;
            end else begin
                o_a_bank_type_bit <= word_ff[POS_A_TYPE];
                o_bcd_bank_type_bit <= word_ff[POS_BCD_TYPE];
                if (!gate_s || !le_s) begin
                    o_out_run <= EN_RESET;
                end else begin
                    o_out_run <= focp_run_bits(word_ff);
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    gate_low_static_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !gate_s |=> o_out_run == 8'h00) else $error("outputs run with gate low");
    gate_high_follow_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        gate_s && le_s && configured_ff |=> o_out_run == $past(word_ff[9:2]))
        else $error("outputs do not follow enables");
    startup_lvds_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !configured_ff |=> o_out_run == 8'h00 && !o_a_bank_type_bit && !o_bcd_bank_type_bit)
        else $error("start-up state not static LVDS");
    type_map_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        configured_ff |=> o_bcd_bank_type_bit == $past(word_ff[1])
        && o_a_bank_type_bit == $past(word_ff[0])) else $error("type bits misrouted");
    strobe_low_stop_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !le_s |=> o_out_run == 8'h00) else $error("outputs run with strobe low");
    load_on_rise_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        le_rise |=> word_ff == $past(shift_ff) && configured_ff)
        else $error("word not loaded on strobe");
    hold_word_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !le_rise |=> $stable(word_ff)) else $error("word changed without strobe");
    shift_msb_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        sclk_rise |=> shift_ff[0] == $past(sdat_s) && shift_ff[9:1] == $past(shift_ff[8:0]))
        else $error("shift register wrong");
    readback_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        sclk_fall |=> o_readback == $past(shift_ff[9])) else $error("read-back wrong");
    ////////////////////////////////////////////////////////////////////
    // Read-back: the strobe also refreshes it, so the host sees D10 first
    strobe_readback_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        le_rise |=> o_readback == $past(shift_ff[9]))
        else $error("read-back not refreshed on strobe");
    readback_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !sclk_fall && !le_rise |=> $stable(o_readback))
        else $error("read-back moved between edges");
    ////////////////////////////////////////////////////////////////////
    // Shift register only moves on a serial clock rise
    shift_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !sclk_rise |=> $stable(shift_ff))
        else $error("shift register moved without clock");
    ////////////////////////////////////////////////////////////////////
    // Configured flag is sticky until reset and mirrored one cycle late
    config_sticky_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        configured_ff |=> configured_ff)
        else $error("configured flag dropped");
    config_mirror_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        1'b1 |=> o_configured == $past(configured_ff))
        else $error("configured output wrong");
    run_needs_cfg_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_out_run != 8'h00 |-> configured_ff)
        else $error("outputs run before first load");
    load_needs_le_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(configured_ff) |-> $past(le_rise))
        else $error("configured without strobe");
    ////////////////////////////////////////////////////////////////////
    // Shifting a new word must not disturb the type of the running outputs
    type_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        configured_ff && $stable(word_ff) |=> $stable(o_a_bank_type_bit)
        && $stable(o_bcd_bank_type_bit)) else $error("type changed without load");
    disabled_static_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        1'b1 |=> (o_out_run & ~$past(focp_run_bits(word_ff))) == 8'h00)
        else $error("disabled output runs");
    // One check per output, so a swapped pair is caught by position
    for (genvar gi = 0; gi < N_OUT; gi++) begin : g_enable_map
        enable_map_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
            gate_s && le_s && configured_ff |=> o_out_run[gi] == $past(word_ff[POS_EN_LO + gi]))
            else $error("enable bit misrouted");
    end
endmodule : focp_port
`default_nettype wire

/* focp_pkg.sv */
/*
 Package for the fanout output configuration port: word layout, bit
 positions, start-up values and output type encoding.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package focp_pkg;
    localparam int WORD_W = 10;
    localparam int N_OUT = 8;
    // Bit positions inside the word (index 0 is the first type bit)
    localparam int POS_A_TYPE = 0;
    localparam int POS_BCD_TYPE = 1;
    localparam int POS_EN_LO = 2;
    localparam logic [9:0] WORD_RESET = 10'h000;
    localparam logic [7:0] EN_RESET = 8'h00;
    localparam logic TYPE_LVDS = 1'b0;
    localparam logic TYPE_LVPECL = 1'b1;
    localparam logic [2:0] SYNC_RESET = 3'h0;
    typedef enum logic [0:0] {
        FOCP_TYPE_LVDS,
        FOCP_TYPE_LVPECL
    } focp_type_t;
endpackage : focp_pkg
`default_nettype wire

/* focp_sync.sv */
/*
 Three-stage input synchroniser with agreement filter.
 Assumes an asynchronous input and a single fast system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module focp_sync
    import focp_pkg::*;
(
    input wire logic i_clk, // System clock
    input wire logic i_rstn, // Synchronous reset, active low
    input wire logic i_async, // Raw pin
    output logic o_level // Filtered level
);
    logic [2:0] stage_ff;
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            stage_ff <= SYNC_RESET;
        end else begin
            stage_ff <= {stage_ff[1:0], i_async};
        end
    end
    // Only the later two stages are looked at; the first may be metastable
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_level <= 1'b0;
        end else if (stage_ff[1] == stage_ff[2]) begin
            o_level <= stage_ff[2];
        end
    end
endmodule : focp_sync
`default_nettype wire

/* focp_host.sv */
/*
 Host model for the serial configuration port: shifts a word, then strobes it.
 Assumes i_clk at 125 MHz; the serial clock is low for eleven i_clk cycles and high for ten.
*/
`timescale 1ns/10ps
`default_nettype none
module focp_host (
    input wire logic i_clk, // System clock
    input wire logic i_readback, // Serial data out of the port
    output logic o_serial_clk, // Serial clock, idle low between frames
    output logic o_serial_data, // Serial data, pulled low when idle
    output logic o_load_strobe // Load strobe
);
    initial begin
        o_serial_clk = 1'b0;
        o_serial_data = 1'b0;
        o_load_strobe = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Readback is sampled just before each rise, long after the last fall
    task automatic send(input logic [9:0] w, output logic [9:0] rb);
        o_load_strobe <= 1'b0;
        for (int i = 9; i >= 0; i--) begin
            @(posedge i_clk) o_serial_data <= w[i];
            repeat (10) @(posedge i_clk);
            rb[i] = i_readback;
            o_serial_clk <= 1'b1;
            repeat (10) @(posedge i_clk);
            o_serial_clk <= 1'b0;
        end
        repeat (10) @(posedge i_clk);
        o_serial_data <= 1'b0;
        o_load_strobe <= 1'b1;
    endtask : send
endmodule : focp_host
`default_nettype wire

/* fanout_output_config_port_test.sv */
/*
 Self-checking bench of the configuration port, driven through the host model.
 Assumes the port's synchroniser latency of four i_clk cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module fanout_output_config_port_test;
    import focp_pkg::*;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_output_gate = 1'b0;
    logic g;
    wire logic sclk, serial_config_in, strobe;
    logic [7:0] o_out_run;
    logic o_a, o_bcd, o_readback, o_configured;
    logic [9:0] w, prev, rb;
    int errors = 0;
    int compares = 0;
    int n;
    always #4 i_clk = ~i_clk;
    focp_host focp_host_inst (.i_clk(i_clk), .i_readback(o_readback),
        .o_serial_clk(sclk), .o_serial_data(serial_config_in), .o_load_strobe(strobe));
    focp_port focp_port_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_serial_clk(sclk),
        .i_serial_config_in(serial_config_in), .i_load_strobe(strobe), .i_output_gate(i_output_gate),
        .o_out_run(o_out_run), .o_a_bank_type_bit(o_a), .o_bcd_bank_type_bit(o_bcd),
        .o_readback(o_readback), .o_configured(o_configured));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] exp_run(input logic [9:0] v, input logic gate);
        return gate ? v[9:2] : 8'h00;
    endfunction : exp_run
    task automatic check(input logic [10:0] got, input logic [10:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(81));
        repeat (5) @(posedge i_clk);
        i_rstn <= 1'b1;
        i_output_gate <= 1'b1;
        repeat (10) @(posedge i_clk);
        check({o_out_run, o_bcd, o_a, o_configured}, 11'h000, "start-up");
        $display("test start-up done");
        for (int t = 0; t < 8; t++) begin
            w = (t == 0) ? 10'h3ff : (t == 1) ? 10'h000 : (t == 2) ? 10'h2aa : 10'($urandom());
            g = 1'($urandom_range(1, 0));
            i_output_gate <= g;
            focp_host_inst.send(w, rb);
            // Strobe has only just risen: previous type must still stand
            if (t > 0) check({9'h0, o_bcd, o_a}, {9'h0, prev[1:0]}, "hold");
            for (n = 0; n < 20 && o_configured !== 1'b1; n++) @(posedge i_clk);
            if (n == 20) begin
                errors++;
                $display("ERROR %0t no load seen", $time);
                end_of_test();
            end
            repeat (10) @(posedge i_clk);
            check({o_out_run, o_bcd, o_a, o_configured}, {exp_run(w, g), w[1:0], 1'b1},
                "load");
            if (t > 0) check({1'b0, rb}, {1'b0, prev}, "readback");
            i_output_gate <= ~g;
            repeat (10) @(posedge i_clk);
            check({3'h0, o_out_run}, {3'h0, exp_run(w, ~g)}, "gate");
            prev = w;
            $display("test word %0d done", t);
        end
        end_of_test();
    end
endmodule : fanout_output_config_port_test
`default_nettype wire
